// *** dv/dslc_host_model.sv ***
// Host command model driving the security controller's command port
`timescale 1ns/10ps
module dslc_host_model (
   // Clock
   input  wire logic                i_ref_clk,
   // Command out
   output logic                     o_cmd_valid,
   output dslc_pkg::dslc_cmd_s      o_cmd,
   // Response in
   input  wire logic                i_rsp_valid,
   input  wire dslc_pkg::dslc_rsp_s i_rsp
);
   dslc_pkg::dslc_rsp_s last_rsp;
   logic                got_rsp;

   // Idle port at time zero
   initial begin
      o_cmd_valid = 1'b0;
      o_cmd       = '0;
   end

   // One-cycle command pulse, then a bounded wait for its completion
   task automatic send(input logic [7:0] op, input logic media, input logic cfg,
                       input logic mst, input logic [15:0] mrev, input logic match);
      got_rsp = 1'b0;
      @(posedge i_ref_clk);
      o_cmd_valid <= 1'b1;
      o_cmd <= '{opcode: op, media: media, cfg: cfg, is_master: mst, level_max: 1'b0,
                 mrev: mrev, pw_match: match};
      @(posedge i_ref_clk);
      o_cmd_valid <= 1'b0;
      // Scramble the opcode so nothing rides on a stale value
      o_cmd.opcode <= ~op;
      for (int n = 0; n < 4 && !got_rsp; n++) begin
         @(posedge i_ref_clk);
         if (i_rsp_valid === 1'b1) begin
            got_rsp  = 1'b1;
            last_rsp = i_rsp;
         end
      end
   endtask
endmodule // dslc_host_model

// *** dv/dslc_top_test.sv ***
// Self-checking bench for the drive security lock controller
`timescale 1ns/10ps
module dslc_top_test;
   logic                i_ref_clk;
   logic                i_sys_rst;
   logic                nv_user_set;
   logic                nv_level_max;
   logic                nv_valid;
   logic [15:0]         nv_mrev;
   logic                cmd_valid;
   dslc_pkg::dslc_cmd_s cmd_bus;
   logic                rsp_valid;
   dslc_pkg::dslc_rsp_s rsp_bus;
   logic [15:0]         mrev;
   logic                wb_cyc;
   logic                wb_stb;
   logic                wb_we;
   logic [7:0]          wb_adr;
   logic [31:0]         wb_dat;
   logic [31:0]         wb_rdat;
   logic                wb_ack;
   logic                irq;
   logic [31:0]         rd;
   int                  fail_count;
   int                  checks_done;
   int                  cycles;
   logic [7:0]          lk_ops [5] = '{8'hC8, 8'hB1, 8'hF5, 8'hF6, 8'hF1};
   logic [7:0]          fz_ops [5] = '{8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF6};

   // ********************************************************************
   // Design and host model
   // ********************************************************************
   dslc_top i_dslc_top (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
      .i_nv_user_set(nv_user_set), .i_nv_level_max(nv_level_max), .i_nv_mrev(nv_mrev),
      .i_nv_valid(nv_valid), .i_cmd_valid(cmd_valid), .i_cmd(cmd_bus),
      .o_rsp_valid(rsp_valid), .o_rsp(rsp_bus), .o_mrev(mrev), .i_wb_cyc(wb_cyc),
      .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(4'hF),
      .i_wb_dat(wb_dat), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .o_irq(irq));
   dslc_host_model i_dslc_host_model (.i_ref_clk(i_ref_clk), .o_cmd_valid(cmd_valid),
      .o_cmd(cmd_bus), .i_rsp_valid(rsp_valid), .i_rsp(rsp_bus));

   // Clock and watchdog; a hang is far beyond the few hundred cycles needed
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles > 8000) begin
         fail_count++;
         complete_run();
      end
   end

   // ********************************************************************
   // Compare, bus and command tasks
   // ********************************************************************
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rsp(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Classic single cycle, held until ack is sampled
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge i_ref_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= adr;
      wb_dat <= dat;
      // No cycle count assumed; only the watchdog ends a hang
      do begin
         @(posedge i_ref_clk);
      end while (wb_ack !== 1'b1);
      rd = wb_rdat;
      chk_rsp(wb_ack, 1'b1);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
      @(posedge i_ref_clk);
   endtask
   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
      wb_xfer(1'b0, adr, 32'h0000_0000);
      chk_reg(rd, exp);
   endtask
   task automatic cmd(input logic [7:0] op, input logic mst, input logic match,
                      input logic exp_abort);
      i_dslc_host_model.send(op, op == 8'hC8, op == 8'hB1, mst, 16'h1234, match);
      chk_rsp(i_dslc_host_model.got_rsp, 1'b1);
      chk_rsp(i_dslc_host_model.last_rsp.abort, exp_abort);
   endtask
   // Reset stands in for power-on; NV inputs model the stored state
   task automatic do_reset(input logic user, input logic lmax);
      @(posedge i_ref_clk);
      i_sys_rst    <= 1'b1;
      nv_user_set  <= user;
      nv_level_max <= lmax;
      repeat (8) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
   endtask
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ********************************************************************
   // Test sequence
   // ********************************************************************
   initial begin
      i_sys_rst = 1'b1;
      nv_user_set = 1'b0;
      nv_level_max = 1'b0;
      nv_valid = 1'b1;
      nv_mrev = 16'hFFFE;
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
      fail_count = 0;
      checks_done = 0;
      cycles = 0;
      do_reset(1'b0, 1'b0);
      rd_chk(dslc_pkg::ADR_STATUS, 32'h0000_0000);
      rd_chk(dslc_pkg::ADR_W92, 32'h0000_FFFE);
      chk_reg({16'h0, mrev}, 32'h0000_FFFE);
      cmd(8'hC8, 1'b0, 1'b0, 1'b0);
      // Master first, as an integrator must, then the user password
      cmd(dslc_pkg::OP_SET_PW, 1'b1, 1'b1, 1'b0);
      chk_rsp(i_dslc_host_model.last_rsp.store_master, 1'b1);
      rd_chk(dslc_pkg::ADR_STATUS, 32'h0000_0000);
      rd_chk(dslc_pkg::ADR_W92, 32'h0000_1234);
      i_dslc_host_model.send(dslc_pkg::OP_SET_PW, 1'b0, 1'b0, 1'b1, 16'hFFFF, 1'b1);
      rd_chk(dslc_pkg::ADR_W92, 32'h0000_1234);
      cmd(dslc_pkg::OP_SET_PW, 1'b0, 1'b1, 1'b0);
      chk_rsp(i_dslc_host_model.last_rsp.store_user, 1'b1);
      nv_mrev <= 16'h1234;
      do_reset(1'b1, 1'b0);
      rd_chk(dslc_pkg::ADR_STATUS, 32'h0000_0001);
      // Abort interrupt: unmasked, raised, then cleared by the read
      wb_xfer(1'b0, dslc_pkg::ADR_IRQ_STAT, 32'h0000_0000);
      wb_xfer(1'b1, dslc_pkg::ADR_IRQ_MASK, 32'h0000_0002);
      cmd(8'hC8, 1'b0, 1'b1, 1'b1);
      chk_rsp(i_dslc_host_model.last_rsp.erase, 1'b0);
      repeat (2) @(posedge i_ref_clk);
      chk_rsp(irq, 1'b1);
      wb_xfer(1'b0, dslc_pkg::ADR_IRQ_STAT, 32'h0000_0000);
      chk_reg(rd & 32'h0000_0002, 32'h0000_0002);
      repeat (2) @(posedge i_ref_clk);
      chk_rsp(irq, 1'b0);
      foreach (lk_ops[i]) cmd(lk_ops[i], 1'b0, 1'b1, 1'b1);
      cmd(dslc_pkg::OP_ERASE_PREP, 1'b0, 1'b1, 1'b0);
      for (int i = 0; i < 4; i++) cmd(dslc_pkg::OP_UNLOCK, i[0], 1'b0, 1'b1);
      rd_chk(dslc_pkg::ADR_FAILS, 32'h0000_0004);
      cmd(dslc_pkg::OP_UNLOCK, 1'b1, 1'b1, 1'b0);
      rd_chk(dslc_pkg::ADR_STATUS, 32'h0000_0000);
      cmd(8'hC8, 1'b0, 1'b1, 1'b0);
      // Attempt limit reached through erase-unit mismatches
      do_reset(1'b1, 1'b0);
      for (int i = 0; i < 5; i++) cmd(dslc_pkg::OP_ERASE_UNIT, i[0], 1'b0, 1'b1);
      wb_xfer(1'b0, dslc_pkg::ADR_W128, 32'h0000_0000);
      chk_reg({31'h0, rd[dslc_pkg::W128_EXH_BIT]}, 32'h0000_0001);
      rd_chk(dslc_pkg::ADR_IRQ_STAT, 32'h0000_0006);
      cmd(dslc_pkg::OP_UNLOCK, 1'b0, 1'b1, 1'b1);
      cmd(dslc_pkg::OP_ERASE_UNIT, 1'b1, 1'b1, 1'b1);
      rd_chk(dslc_pkg::ADR_STATUS, 32'h0000_0001);
      do_reset(1'b1, 1'b0);
      wb_xfer(1'b0, dslc_pkg::ADR_W128, 32'h0000_0000);
      chk_reg({31'h0, rd[dslc_pkg::W128_EXH_BIT]}, 32'h0000_0000);
      rd_chk(dslc_pkg::ADR_FAILS, 32'h0000_0000);
      // Maximum level: master unlock refused, erase-unit with the master password unlocks
      do_reset(1'b1, 1'b1);
      cmd(dslc_pkg::OP_UNLOCK, 1'b1, 1'b1, 1'b1);
      rd_chk(dslc_pkg::ADR_FAILS, 32'h0000_0000);
      cmd(dslc_pkg::OP_ERASE_UNIT, 1'b1, 1'b1, 1'b0);
      chk_rsp(i_dslc_host_model.last_rsp.erase, 1'b1);
      chk_rsp(i_dslc_host_model.last_rsp.clear_user, 1'b1);
      rd_chk(dslc_pkg::ADR_STATUS, 32'h0000_0000);
      // Frozen: password and lock changes refused, nothing leaves it
      cmd(dslc_pkg::OP_FREEZE, 1'b0, 1'b1, 1'b0);
      rd_chk(dslc_pkg::ADR_STATUS, 32'h0000_0002);
      foreach (fz_ops[i]) cmd(fz_ops[i], 1'b1, 1'b1, 1'b1);
      cmd(8'hC8, 1'b0, 1'b1, 1'b0);
      cmd(dslc_pkg::OP_FREEZE, 1'b0, 1'b1, 1'b0);
      wb_xfer(1'b1, dslc_pkg::ADR_STATUS, 32'h0000_0000);
      rd_chk(dslc_pkg::ADR_STATUS, 32'h0000_0002);
      rd_chk(8'h1C, dslc_pkg::UNMAPPED_RD);
      complete_run();
   end
endmodule // dslc_top_test

// *** logic/dslc_fail_cnt.sv ***
// Failed-attempt counter with attempts-exhausted flag
`timescale 1ns/10ps
module dslc_fail_cnt #(
   parameter logic [2:0] LIMIT = dslc_pkg::FAIL_LIMIT
) (
   // Clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_sys_rst,
   // Events
   input  wire logic       i_mismatch,
   // State
   output logic [2:0]      o_count,
   output logic            o_attempts_exhausted_flag
);
   logic [2:0] cnt_q;

   // Saturating count; reset stands for power-on or hard reset
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         cnt_q <= 3'd0;
      end else if (i_mismatch && cnt_q != LIMIT) begin
         cnt_q <= cnt_q + 3'd1;
      end
   end

   assign o_count = cnt_q;
   assign o_attempts_exhausted_flag = (cnt_q == LIMIT);

   AST_CNT_SAT: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      cnt_q == LIMIT |=> cnt_q == LIMIT)
      else $error("exhausted count left the limit");
endmodule // dslc_fail_cnt

// *** logic/dslc_pkg.sv ***
// Package for the drive security lock controller: opcodes, map, fields, types
package dslc_pkg;
   // ********************************************************************
   // Security opcodes
   // ********************************************************************
   localparam logic [7:0] OP_SET_PW     = 8'hF1;
   localparam logic [7:0] OP_UNLOCK     = 8'hF2;
   localparam logic [7:0] OP_ERASE_PREP = 8'hF3;
   localparam logic [7:0] OP_ERASE_UNIT = 8'hF4;
   localparam logic [7:0] OP_FREEZE     = 8'hF5;
   localparam logic [7:0] OP_DISABLE_PW = 8'hF6;
   localparam logic [7:0] OP_SEC_FIRST  = 8'hF1;
   localparam logic [7:0] OP_SEC_LAST   = 8'hF6;

   // ********************************************************************
   // Limits and identify data
   // ********************************************************************
   localparam logic [2:0]  FAIL_LIMIT     = 3'd5;
   localparam logic [15:0] MREV_DEFAULT   = 16'hFFFE;
   localparam logic [15:0] MREV_MIN       = 16'h0001;
   localparam logic [15:0] MREV_MAX       = 16'hFFFE;
   localparam int          W128_EXH_BIT   = 4;
   localparam int          W128_EN_BIT    = 1;
   localparam int          W128_LOCK_BIT  = 2;
   localparam int          W128_FRZ_BIT   = 3;
   localparam int          W128_LVL_BIT   = 8;

   // ********************************************************************
   // Wishbone register map (byte addresses)
   // ********************************************************************
   localparam logic [7:0] ADR_STATUS   = 8'h00;
   localparam logic [7:0] ADR_W92      = 8'h04;
   localparam logic [7:0] ADR_W128     = 8'h08;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h0C;
   localparam logic [7:0] ADR_IRQ_MASK = 8'h10;
   localparam logic [7:0] ADR_FAILS    = 8'h14;
   localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

   // Interrupt status bits
   localparam int IRQ_DONE    = 0;
   localparam int IRQ_ABORT   = 1;
   localparam int IRQ_EXHAUST = 2;
   localparam int IRQ_W       = 3;

   // Security mode
   typedef enum logic [1:0] {
      MODE_UNLOCKED = 2'b00,
      MODE_LOCKED   = 2'b01,
      MODE_FROZEN   = 2'b10
   } dslc_mode_e;

   // Command presented by the front end
   typedef struct packed {
      logic [7:0]  opcode;
      logic        media;    // read/write/verify/format class
      logic        cfg;      // config-set, max-address, service
      logic        is_master; // password field selects master
      logic        level_max; // set-password level bit
      logic [15:0] mrev;     // revision code with master set
      logic        pw_match; // compare result from password store
   } dslc_cmd_s;

   // Completion
   typedef struct packed {
      logic abort;
      logic erase;      // erase all user data
      logic store_user;
      logic store_master;
      logic clear_user;
   } dslc_rsp_s;
endpackage : dslc_pkg

// *** logic/dslc_top.sv ***
// Drive security lock controller with Wishbone registers and interrupt
`timescale 1ns/10ps
module dslc_top (
   // Clock and reset
   input  wire logic             i_ref_clk,
   input  wire logic             i_sys_rst,
   // Non-volatile state sampled at reset release
   input  wire logic             i_nv_user_set,
   input  wire logic             i_nv_level_max,
   input  wire logic [15:0]      i_nv_mrev,
   input  wire logic             i_nv_valid,
   // Command port
   input  wire logic             i_cmd_valid,
   input  wire dslc_pkg::dslc_cmd_s i_cmd,
   output logic                  o_rsp_valid,
   output dslc_pkg::dslc_rsp_s   o_rsp,
   output logic [15:0]           o_mrev,
   // Wishbone slave
   input  wire logic             i_wb_cyc,
   input  wire logic             i_wb_stb,
   input  wire logic             i_wb_we,
   input  wire logic [7:0]       i_wb_adr,
   input  wire logic [3:0]       i_wb_sel,
   input  wire logic [31:0]      i_wb_dat,
   output logic [31:0]           o_wb_dat,
   output logic                  o_wb_ack,
   // Interrupt
   output logic                  o_irq
);
   // ********************************************************************
   // State
   // ********************************************************************
   dslc_pkg::dslc_mode_e mode_q;
   logic        lock_en_q, level_max_q, loaded_q;
   logic [15:0] mrev_q;
   logic        rsp_valid_q;
   dslc_pkg::dslc_rsp_s rsp_q;
   logic [dslc_pkg::IRQ_W-1:0] irq_stat_q, irq_mask_q;
   logic        ack_q;
   logic [31:0] rdat_q;
   logic [2:0]  fail_cnt;
   logic        exhausted, mismatch;
   logic        frozen_q;

   function automatic logic is_sec(input logic [7:0] op);
      is_sec = op >= dslc_pkg::OP_SEC_FIRST && op <= dslc_pkg::OP_SEC_LAST;
   endfunction

   // ********************************************************************
   // Command decision
   // ********************************************************************
   logic abort_c, unlock_ok, erase_ok, set_ok, dis_ok, frz_ok;
   logic pw_cmd;
   always_comb begin
      abort_c   = 1'b0;
      unlock_ok = 1'b0;
      erase_ok  = 1'b0;
      set_ok    = 1'b0;
      dis_ok    = 1'b0;
      frz_ok    = 1'b0;
      pw_cmd    = 1'b0;
      case (i_cmd.opcode)
         dslc_pkg::OP_SET_PW: begin
            abort_c = mode_q != dslc_pkg::MODE_UNLOCKED;
            set_ok  = !abort_c;
         end
         dslc_pkg::OP_UNLOCK: begin
            pw_cmd  = 1'b1;
            // Max level refuses master for unlock
            abort_c = mode_q == dslc_pkg::MODE_FROZEN || exhausted ||
                      (i_cmd.is_master && level_max_q) || !i_cmd.pw_match;
            unlock_ok = !abort_c;
         end
         dslc_pkg::OP_ERASE_PREP: begin
            abort_c = mode_q == dslc_pkg::MODE_FROZEN;
         end
         dslc_pkg::OP_ERASE_UNIT: begin
            pw_cmd  = 1'b1;
            abort_c = mode_q == dslc_pkg::MODE_FROZEN || exhausted ||
                      !i_cmd.pw_match;
            erase_ok = !abort_c;
         end
         dslc_pkg::OP_FREEZE: begin
            abort_c = mode_q == dslc_pkg::MODE_LOCKED;
            frz_ok  = !abort_c;
         end
         dslc_pkg::OP_DISABLE_PW: begin
            pw_cmd  = 1'b1;
            abort_c = mode_q != dslc_pkg::MODE_UNLOCKED || !i_cmd.pw_match;
            dis_ok  = !abort_c;
         end
         default: begin
            abort_c = mode_q == dslc_pkg::MODE_LOCKED &&
                      (i_cmd.media || i_cmd.cfg);
         end
      endcase
   end
   // Only a mismatch on a password command, outside frozen and exhausted, counts
   assign mismatch = i_cmd_valid && loaded_q && pw_cmd && !i_cmd.pw_match &&
                     mode_q != dslc_pkg::MODE_FROZEN && !exhausted;

   dslc_fail_cnt #(
      .LIMIT (dslc_pkg::FAIL_LIMIT)
   ) u_fail (
      .i_ref_clk                 (i_ref_clk),
      .i_sys_rst                 (i_sys_rst),
      .i_mismatch                (mismatch),
      .o_count                   (fail_cnt),
      .o_attempts_exhausted_flag (exhausted)
   );

   // ********************************************************************
   // Mode machine; non-volatile state caught after reset release
   // ********************************************************************
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         mode_q   <= dslc_pkg::MODE_LOCKED;
         loaded_q <= 1'b0;
      end else if (!loaded_q) begin
         if (i_nv_valid) begin
            loaded_q <= 1'b1;
            mode_q   <= i_nv_user_set ? dslc_pkg::MODE_LOCKED
                                      : dslc_pkg::MODE_UNLOCKED;
         end
      end else if (i_cmd_valid) begin
         case (mode_q)
            dslc_pkg::MODE_LOCKED: begin
               if (unlock_ok || erase_ok) begin
                  mode_q <= dslc_pkg::MODE_UNLOCKED;
               end
            end
            dslc_pkg::MODE_UNLOCKED: begin
               if (frz_ok) begin
                  mode_q <= dslc_pkg::MODE_FROZEN;
               end
            end
            dslc_pkg::MODE_FROZEN: begin
               mode_q <= dslc_pkg::MODE_FROZEN;
            end
            default: begin
               mode_q <= dslc_pkg::MODE_LOCKED;
            end
         endcase
      end
   end
   assign frozen_q = mode_q == dslc_pkg::MODE_FROZEN;

   // ********************************************************************
   // Lock enable, level and master revision code
   // ********************************************************************
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         lock_en_q   <= 1'b0;
         level_max_q <= 1'b0;
         mrev_q      <= dslc_pkg::MREV_DEFAULT;
      end else if (!loaded_q) begin
         if (i_nv_valid) begin
            lock_en_q   <= i_nv_user_set;
            level_max_q <= i_nv_level_max;
            if (i_nv_mrev >= dslc_pkg::MREV_MIN && i_nv_mrev <= dslc_pkg::MREV_MAX) begin
               mrev_q <= i_nv_mrev;
            end
         end
      end else if (i_cmd_valid) begin
         if (set_ok && i_cmd.is_master) begin
            // Master never touches lock enable
            if (i_cmd.mrev >= dslc_pkg::MREV_MIN && i_cmd.mrev <= dslc_pkg::MREV_MAX) begin
               mrev_q <= i_cmd.mrev;
            end
         end else if (set_ok) begin
            lock_en_q   <= 1'b1;
            level_max_q <= i_cmd.level_max;
         end else if (dis_ok || erase_ok) begin
            lock_en_q   <= 1'b0;
         end
      end
   end
   assign o_mrev = mrev_q;

   // ********************************************************************
   // Completion to the command front end
   // ********************************************************************
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         rsp_valid_q <= 1'b0;
         rsp_q       <= '0;
      end else begin
         rsp_valid_q        <= i_cmd_valid && loaded_q;
         rsp_q.abort        <= abort_c;
         rsp_q.erase        <= i_cmd_valid && erase_ok;
         rsp_q.store_user   <= i_cmd_valid && set_ok && !i_cmd.is_master;
         rsp_q.store_master <= i_cmd_valid && set_ok && i_cmd.is_master;
         rsp_q.clear_user   <= i_cmd_valid && (dis_ok || erase_ok);
      end
   end
   assign o_rsp_valid = rsp_valid_q;
   assign o_rsp       = rsp_q;

   // ********************************************************************
   // Interrupt status: set wins over read-clear
   // ********************************************************************
   logic [dslc_pkg::IRQ_W-1:0] irq_set;
   logic rd_stat;
   assign irq_set[dslc_pkg::IRQ_DONE]    = rsp_valid_q && !rsp_q.abort;
   assign irq_set[dslc_pkg::IRQ_ABORT]   = rsp_valid_q && rsp_q.abort;
   assign irq_set[dslc_pkg::IRQ_EXHAUST] = mismatch && fail_cnt == dslc_pkg::FAIL_LIMIT - 3'd1;
   assign rd_stat = i_wb_cyc && i_wb_stb && !i_wb_we && !ack_q &&
                    i_wb_adr == dslc_pkg::ADR_IRQ_STAT;
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         irq_stat_q <= '0;
      end else begin
         irq_stat_q <= (rd_stat ? '0 : irq_stat_q) | irq_set;
      end
   end
   assign o_irq = |(irq_stat_q & irq_mask_q);

   // ********************************************************************
   // Wishbone slave, one wait state, ack drops after one cycle
   // ********************************************************************
   logic [31:0] w128;
   always_comb begin
      w128 = '0;
      w128[0]                       = 1'b1;
      w128[dslc_pkg::W128_EN_BIT]   = lock_en_q;
      w128[dslc_pkg::W128_LOCK_BIT] = mode_q == dslc_pkg::MODE_LOCKED;
      w128[dslc_pkg::W128_FRZ_BIT]  = frozen_q;
      w128[dslc_pkg::W128_EXH_BIT]  = exhausted;
      w128[dslc_pkg::W128_LVL_BIT]  = level_max_q;
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         ack_q      <= 1'b0;
         rdat_q     <= '0;
         irq_mask_q <= '0;
      end else begin
         ack_q <= i_wb_cyc && i_wb_stb && !ack_q;
         if (i_wb_cyc && i_wb_stb && !ack_q) begin
            if (i_wb_we && i_wb_sel[0] && i_wb_adr == dslc_pkg::ADR_IRQ_MASK) begin
               irq_mask_q <= i_wb_dat[dslc_pkg::IRQ_W-1:0];
            end
            case (i_wb_adr)
               dslc_pkg::ADR_STATUS:   rdat_q <= {30'd0, mode_q};
               dslc_pkg::ADR_W92:      rdat_q <= {16'd0, mrev_q};
               dslc_pkg::ADR_W128:     rdat_q <= w128;
               dslc_pkg::ADR_IRQ_STAT: rdat_q <= {29'd0, irq_stat_q};
               dslc_pkg::ADR_IRQ_MASK: rdat_q <= {29'd0, irq_mask_q};
               dslc_pkg::ADR_FAILS:    rdat_q <= {29'd0, fail_cnt};
               default:                rdat_q <= dslc_pkg::UNMAPPED_RD;
            endcase
         end
      end
   end
   assign o_wb_ack = ack_q;
   assign o_wb_dat = rdat_q;

   // ********************************************************************
   // Checks
   // ********************************************************************
   sequence s_locked_media;
      i_cmd_valid && loaded_q && mode_q == dslc_pkg::MODE_LOCKED &&
      i_cmd.media && !is_sec(i_cmd.opcode);
   endsequence
   AST_LOCK_MEDIA: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      s_locked_media |=> o_rsp_valid && o_rsp.abort)
      else $error("media command passed while locked");
   AST_FROZEN_STAYS: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      frozen_q |=> frozen_q)
      else $error("left frozen state");
   AST_FREEZE_GO: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_cmd_valid && loaded_q && mode_q == dslc_pkg::MODE_UNLOCKED &&
      i_cmd.opcode == dslc_pkg::OP_FREEZE |=> frozen_q)
      else $error("freeze did not freeze");
   AST_FROZEN_SET: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_cmd_valid && loaded_q && frozen_q &&
      (i_cmd.opcode == dslc_pkg::OP_SET_PW || i_cmd.opcode == dslc_pkg::OP_UNLOCK)
      |=> o_rsp.abort && !o_rsp.store_user)
      else $error("password command ran while frozen");
   AST_MASTER_NOLOCK: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      o_rsp_valid && o_rsp.store_master && !$past(lock_en_q) |-> !lock_en_q)
      else $error("master password enabled lock");
   AST_USER_LOCK: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      o_rsp_valid && o_rsp.store_user |-> lock_en_q)
      else $error("user password did not enable lock");
   AST_EXH_ABORT: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_cmd_valid && loaded_q && exhausted && i_cmd.opcode == dslc_pkg::OP_ERASE_UNIT
      |=> o_rsp.abort && !o_rsp.erase)
      else $error("erase ran after attempts exhausted");
   AST_MAX_MASTER: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_cmd_valid && loaded_q && level_max_q && i_cmd.is_master &&
      i_cmd.opcode == dslc_pkg::OP_UNLOCK ##1 1'b1 |-> o_rsp.abort)
      else $error("master unlocked at maximum level");
   AST_MREV_RANGE: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      mrev_q >= dslc_pkg::MREV_MIN && mrev_q <= dslc_pkg::MREV_MAX)
      else $error("revision code out of range");
   AST_ACK_PULSE: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      o_wb_ack |=> !o_wb_ack)
      else $error("ack held two cycles");
endmodule // dslc_top
